// ==== core/epcl_pkg.sv ====
// package for the eeprom port configuration loader: offsets, field
// positions, reset values, word addresses, state and carrier types.
// assumes a six-port switch core that consumes the loaded fields.
package epcl_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned EPCL_NPORT = 6;
  localparam logic [4:0]  EPCL_LAST_STEP = 5'h1b;  // 28 words, 0..27

  // ****************************************************************
  // eeprom word addresses (first port of each group)
  // ****************************************************************
  localparam logic [7:0] EPCL_EE_PM_BASE   = 8'h80;  // ports 0..5
  localparam logic [7:0] EPCL_EE_SLOT_LO   = 8'h92;  // ports 1..5
  localparam logic [7:0] EPCL_EE_SLOT_HI   = 8'ha2;  // ports 1..5
  localparam logic [7:0] EPCL_EE_TUNE_LO   = 8'hb0;  // ports 0..5
  localparam logic [7:0] EPCL_EE_TUNE_HI   = 8'hc0;  // ports 0..5
  localparam logic [7:0] EPCL_EE_STRIDE    = 8'h02;

  // step index where each group starts
  localparam logic [4:0] EPCL_STEP_SLOT_LO = 5'h06;
  localparam logic [4:0] EPCL_STEP_SLOT_HI = 5'h0b;
  localparam logic [4:0] EPCL_STEP_TUNE_LO = 5'h10;
  localparam logic [4:0] EPCL_STEP_TUNE_HI = 5'h16;

  // ****************************************************************
  // configuration offsets and bus map
  // ****************************************************************
  localparam logic [7:0]  EPCL_OFS_VGA   = 8'h70;
  localparam logic [7:0]  EPCL_OFS_PM    = 8'h74;
  localparam logic [7:0]  EPCL_OFS_TUNE  = 8'h80;
  localparam logic [7:0]  EPCL_OFS_LINK  = 8'h88;
  localparam logic [7:0]  EPCL_OFS_SLOT  = 8'hd4;
  localparam logic [11:0] EPCL_ADR_CTRL  = 12'h800;
  localparam logic [11:0] EPCL_ADR_STAT  = 12'h804;
  localparam int unsigned EPCL_CTRL_RELOAD = 0;
  localparam int unsigned EPCL_STAT_DONE   = 0;
  localparam int unsigned EPCL_STAT_BUSY   = 1;
  localparam int unsigned EPCL_STAT_STEP   = 8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned EPCL_PM_VGA_SRC  = 7;
  localparam int unsigned EPCL_VGA_DST     = 31;
  localparam int unsigned EPCL_PM_DST_LSB  = 8;   // word 6:0 -> 14:8
  localparam int unsigned EPCL_LINK_DST_LSB = 24; // word 15:8 -> 31:24

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] EPCL_RST_VGA  = 32'h0000_0000;
  localparam logic [31:0] EPCL_RST_PM   = 32'h0000_0000;
  localparam logic [31:0] EPCL_RST_TUNE = 32'h0000_0000;
  localparam logic [31:0] EPCL_RST_LINK = 32'h0000_0000;
  localparam logic [31:0] EPCL_RST_SLOT = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    EPCL_S_LOAD  = 2'b01,
    EPCL_S_READY = 2'b10
  } epcl_state_t;

  typedef enum logic [2:0] {
    EPCL_K_PM      = 3'h0,
    EPCL_K_SLOT_LO = 3'h1,
    EPCL_K_SLOT_HI = 3'h2,
    EPCL_K_TUNE_LO = 3'h3,
    EPCL_K_TUNE_HI = 3'h4
  } epcl_kind_t;

  // one eeprom word: where it comes from and where it goes
  typedef struct packed {
    epcl_kind_t kind;
    logic [2:0] port;
    logic [7:0] addr;
  } epcl_step_t;

  // per-port configuration words touched by the loader
  typedef struct packed {
    logic [31:0] vga;   // offset 70h
    logic [31:0] pm;    // offset 74h
    logic [31:0] tune;  // offset 80h, link_tuning_word_three
    logic [31:0] link;  // offset 88h, link_tuning_word_five
    logic [31:0] slot;  // offset d4h
  } epcl_port_cfg_t;

  typedef struct packed {
    epcl_state_t                    st;
    logic [4:0]                     step;
    logic                           req;
    logic [7:0]                     ee_addr;
    logic                           done;
    logic                           pend;
    logic                           pwr;
    logic [11:0]                    paddr;
    logic                           rdy;
    logic [31:0]                    rdata;
    logic                           resp;
    epcl_port_cfg_t [EPCL_NPORT-1:0] cfg;
  } epcl_state_s_t;

endpackage

// ==== core/epcl_step_map.sv ====
// step decoder: maps a load step index to its eeprom word address,
// target port and field group. purely combinational.
`timescale 1ns/1ps
`default_nettype none
module epcl_step_map
  import epcl_pkg::*;
(
  // step in
  input  wire logic [4:0] step,
  // decoded step out
  output epcl_step_t      dec
);

  logic [4:0] rel;

  // ****************************************************************
  // group decode
  // ****************************************************************
  // pick the group, port and word address from the step index
  always_comb
  begin
    rel = 5'h00;
    dec.kind = EPCL_K_PM;
    dec.port = 3'h0;
    dec.addr = EPCL_EE_PM_BASE;
    if (step < EPCL_STEP_SLOT_LO)
    begin
      rel = step;
      dec.kind = EPCL_K_PM;
      dec.port = rel[2:0];
      dec.addr = EPCL_EE_PM_BASE + {2'h0, rel, 1'b0};
    end
    else if (step < EPCL_STEP_SLOT_HI)
    begin
      rel = step - EPCL_STEP_SLOT_LO;
      dec.kind = EPCL_K_SLOT_LO;
      dec.port = rel[2:0] + 3'h1;
      dec.addr = EPCL_EE_SLOT_LO + {2'h0, rel, 1'b0};
    end
    else if (step < EPCL_STEP_TUNE_LO)
    begin
      rel = step - EPCL_STEP_SLOT_HI;
      dec.kind = EPCL_K_SLOT_HI;
      dec.port = rel[2:0] + 3'h1;
      dec.addr = EPCL_EE_SLOT_HI + {2'h0, rel, 1'b0};
    end
    else if (step < EPCL_STEP_TUNE_HI)
    begin
      rel = step - EPCL_STEP_TUNE_LO;
      dec.kind = EPCL_K_TUNE_LO;
      dec.port = rel[2:0];
      dec.addr = EPCL_EE_TUNE_LO + {2'h0, rel, 1'b0};
    end
    else
    begin
      rel = step - EPCL_STEP_TUNE_HI;
      dec.kind = EPCL_K_TUNE_HI;
      dec.port = rel[2:0];
      dec.addr = EPCL_EE_TUNE_HI + {2'h0, rel, 1'b0};
    end
  end

endmodule
`default_nettype wire

// ==== core/epcl_loader.sv ====
// eeprom port configuration loader: fetches 28 eeprom words after reset
// and spreads them into per-port configuration fields, then serves the
// fields to software over ahb-lite.
// assumes the word reader answers ee_req with a one-cycle ee_ack on
// sys_clk, ee_data valid in that cycle; bus signals are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module epcl_loader
  import epcl_pkg::*;
(
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  // ahb-lite slave
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic [31:0]                          hrdata,
  output logic                                 hresp,
  // eeprom word reader
  output logic                                 ee_req,
  output logic [7:0]                           ee_addr,
  input  wire logic                            ee_ack,
  input  wire logic [15:0]                     ee_data,
  // switch core side
  output logic                                 load_done,
  output epcl_port_cfg_t [EPCL_NPORT-1:0]      port_cfg
);

  epcl_state_s_t s_q;
  epcl_state_s_t s_d;
  epcl_step_t    cur;
  logic          accept;
  logic [11:0]   req_addr;
  logic          unused_bits;

  // ****************************************************************
  // step decode
  // ****************************************************************
  epcl_step_map u_map (
    .step (s_q.step),
    .dec  (cur)
  );

  // address phase taken when selected, nonseq or seq (htrans[1]) and bus ready
  assign accept      = hsel & htrans[1] & hready;
  assign req_addr    = {haddr[11:2], 2'b00};
  assign unused_bits = ^{haddr[31:12], haddr[1:0], hsize, htrans[0]};

  // ****************************************************************
  // register read mux
  // ****************************************************************
  function automatic logic [31:0] rd_mux(input epcl_state_s_t s,
                                         input logic [11:0] a);
    logic [31:0] v;
    logic [2:0]  p;
    v = 32'h0000_0000;
    p = a[10:8];
    if (a == EPCL_ADR_STAT)
    begin
      v[EPCL_STAT_DONE] = s.done;
      v[EPCL_STAT_BUSY] = (s.st == EPCL_S_LOAD);
      v[EPCL_STAT_STEP +: 5] = s.step;
    end
    else if (a[11] == 1'b0 && p < 3'(EPCL_NPORT))
    begin
      case (a[7:0])
        EPCL_OFS_VGA:  v = s.cfg[p].vga;
        EPCL_OFS_PM:   v = s.cfg[p].pm;
        EPCL_OFS_TUNE: v = s.cfg[p].tune;
        EPCL_OFS_LINK: v = s.cfg[p].link;
        EPCL_OFS_SLOT: v = s.cfg[p].slot;
        default:       v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // load sequencer, field distribution and bus slave in one process
  always_comb
  begin
    s_d = s_q;
    s_d.resp = 1'b0;
    case (s_q.st)
      EPCL_S_LOAD:
      begin
        if (!s_q.req)
        begin
          s_d.req = 1'b1;
          s_d.ee_addr = cur.addr;
        end
        else if (ee_ack)
        begin
          s_d.req = 1'b0;
          case (cur.kind)
            EPCL_K_PM:
            begin
              s_d.cfg[cur.port].pm[EPCL_PM_DST_LSB +: 7] = ee_data[6:0];
              s_d.cfg[cur.port].vga[EPCL_VGA_DST] = ee_data[EPCL_PM_VGA_SRC];
              s_d.cfg[cur.port].link[EPCL_LINK_DST_LSB +: 8] = ee_data[15:8];
            end
            EPCL_K_SLOT_LO: s_d.cfg[cur.port].slot[15:0]  = ee_data;
            EPCL_K_SLOT_HI: s_d.cfg[cur.port].slot[31:16] = ee_data;
            EPCL_K_TUNE_LO: s_d.cfg[cur.port].tune[15:0]  = ee_data;
            EPCL_K_TUNE_HI: s_d.cfg[cur.port].tune[31:16] = ee_data;
            default:        s_d.req = 1'b0;
          endcase
          if (s_q.step == EPCL_LAST_STEP)
          begin
            s_d.st = EPCL_S_READY;
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.step = s_q.step + 5'h01;
          end
        end
      end
      EPCL_S_READY:
      begin
        s_d.req = 1'b0;
      end
      default:
      begin
        s_d.st = EPCL_S_LOAD;
        s_d.req = 1'b0;
      end
    endcase

    // data phase: held with wait states until the load has finished
    if (s_q.pend && s_q.done)
    begin
      s_d.pend = 1'b0;
      s_d.rdy = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (!s_q.pwr)
      begin
        s_d.rdata = rd_mux(s_q, s_q.paddr);
      end
      else if (s_q.paddr == EPCL_ADR_CTRL && hwdata[EPCL_CTRL_RELOAD])
      begin
        // reload: fields return to reset values, then fill again
        s_d.st = EPCL_S_LOAD;
        s_d.step = 5'h00;
        s_d.done = 1'b0;
        s_d.req = 1'b0;
        for (int i = 0; i < EPCL_NPORT; i++)
        begin
          s_d.cfg[i] = '{vga: EPCL_RST_VGA, pm: EPCL_RST_PM,
                         tune: EPCL_RST_TUNE, link: EPCL_RST_LINK,
                         slot: EPCL_RST_SLOT};
        end
      end
    end

    // address phase: always at least one wait state
    if (accept)
    begin
      s_d.pend = 1'b1;
      s_d.rdy = 1'b0;
      s_d.pwr = hwrite;
      s_d.paddr = req_addr;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // all fields start at reset values, load begins at release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.st <= EPCL_S_LOAD;
      s_q.step <= 5'h00;
      s_q.req <= 1'b0;
      s_q.ee_addr <= 8'h00;
      s_q.done <= 1'b0;
      s_q.pend <= 1'b0;
      s_q.pwr <= 1'b0;
      s_q.paddr <= 12'h000;
      s_q.rdy <= 1'b1;
      s_q.rdata <= 32'h0000_0000;
      s_q.resp <= 1'b0;
      for (int i = 0; i < EPCL_NPORT; i++)
      begin
        s_q.cfg[i] <= '{vga: EPCL_RST_VGA, pm: EPCL_RST_PM,
                        tune: EPCL_RST_TUNE, link: EPCL_RST_LINK,
                        slot: EPCL_RST_SLOT};
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every output straight from the state register
  assign hreadyout = s_q.rdy;
  assign hrdata    = s_q.rdata;
  assign hresp     = s_q.resp;
  assign ee_req    = s_q.req;
  assign ee_addr   = s_q.ee_addr;
  assign load_done = s_q.done;
  assign port_cfg  = s_q.cfg;

endmodule
`default_nettype wire

// ==== dv/epcl_ee_model.sv ====
// eeprom word reader stand-in: one-cycle ack, prompt or slow.
// assumes the loader holds ee_req and ee_addr until the ack edge.
`timescale 1ns/1ps
`default_nettype none
module epcl_ee_model
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // request side
  input  wire logic        ee_req,
  input  wire logic [7:0]  ee_addr,
  input  wire logic        slow,
  // answer side
  output logic             ee_ack,
  output logic [15:0]      ee_data
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_q;
  // answer after wait_q idle cycles; data scrambles when not acked
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ee_ack  <= 1'b0;
      ee_data <= 16'hffff;
      wait_q  <= 2'h0;
    end
    else if (ee_ack || !ee_req)
    begin
      ee_ack  <= 1'b0;
      ee_data <= ~ee_data;
      wait_q  <= slow ? ee_addr[2:1] + 2'h1 : 2'h0;
    end
    else if (wait_q != 2'h0)
    begin
      wait_q  <= wait_q - 2'h1;
      ee_data <= ~ee_data;
    end
    else
    begin
      ee_ack  <= 1'b1;
      ee_data <= mem[ee_addr];
    end
  end
endmodule
`default_nettype wire

// ==== dv/epcl_loader_asserts.sv ====
// checker for the loader: eeprom handshake, field spreading, bus stall.
// assumes it is bound to epcl_loader and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module epcl_loader_asserts
  import epcl_pkg::*;
(
  // clock and reset
  input wire logic                            sys_clk,
  input wire logic                            rst_n,
  // bus
  input wire logic                            hsel,
  input wire logic [1:0]                      htrans,
  input wire logic                            hready,
  input wire logic                            hreadyout,
  input wire logic                            hresp,
  // eeprom and core
  input wire logic                            ee_req,
  input wire logic [7:0]                      ee_addr,
  input wire logic                            ee_ack,
  input wire logic [15:0]                     ee_data,
  input wire logic                            load_done,
  input wire epcl_port_cfg_t [EPCL_NPORT-1:0] port_cfg
);
  logic           tk_q;
  logic [7:0]     a_q;
  logic [15:0]    d_q;
  epcl_port_cfg_t c;
  // remember the word taken at the last edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tk_q <= 1'b0;
    else
      tk_q <= ee_req && ee_ack;
  end
  always_ff @(posedge sys_clk)
  begin
    a_q <= ee_addr;
    d_q <= ee_data;
  end
  // the port is word address bits 3:1 in every group
  assign c = port_cfg[a_q[3:1]];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ****
  // field spreading
  // ****
  chk_pm_split: assert property (
    tk_q && a_q[7:4] == 4'h8 |-> c.pm == {17'h0, d_q[6:0], 8'h00}) else $error("power split");
  chk_vga_bit: assert property (
    tk_q && a_q[7:4] == 4'h8 |-> c.vga == {d_q[7], 31'h0}) else $error("vga bit");
  chk_link_byte: assert property (
    tk_q && a_q[7:4] == 4'h8 |-> c.link == {d_q[15:8], 24'h0}) else $error("link byte");
  chk_slot_low: assert property (
    tk_q && a_q[7:4] == 4'h9 |-> c.slot[15:0] == d_q) else $error("slot low");
  chk_slot_high: assert property (
    tk_q && a_q[7:4] == 4'ha |-> c.slot[31:16] == d_q) else $error("slot high");
  chk_tune_low: assert property (
    tk_q && a_q[7:4] == 4'hb |-> c.tune[15:0] == d_q) else $error("tune low");
  chk_tune_high: assert property (
    tk_q && a_q[7:4] == 4'hc |-> c.tune[31:16] == d_q) else $error("tune high");
  // ****
  // handshake and bus
  // ****
  chk_req_hold: assert property (
    ee_req && !ee_ack |=> ee_req && $stable(ee_addr)) else $error("request dropped");
  chk_word_order: assert property (
    ee_req && ee_ack && ee_addr != 8'hca |=> !ee_req ##1 ee_req && ee_addr > $past(ee_addr, 2)
    && ee_addr - $past(ee_addr, 2) <= 8'h08) else $error("word order");
  chk_done_last: assert property (
    ee_req && ee_ack && ee_addr == 8'hca |=> load_done && !ee_req) else $error("done late");
  chk_bus_stall: assert property (
    hsel && htrans[1] && hready && !load_done |=> !hreadyout) else $error("bus not held");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  cover property ($rose(load_done));
  cover property (!hreadyout && !load_done);
  cover property (tk_q && a_q == 8'h9a);
endmodule
bind epcl_loader epcl_loader_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ee_req(ee_req),
  .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data), .load_done(load_done),
  .port_cfg(port_cfg));
`default_nettype wire

// ==== dv/epcl_loader_tb_top.sv ====
// bench for the loader: eeprom stand-in, ahb-lite master, table model.
// assumes the loader is the only ahb slave, so hready = hreadyout.
`timescale 1ns/1ps
`default_nettype none
module epcl_loader_tb_top
  import epcl_pkg::*;
;
  logic                            sys_clk = 1'b0;
  logic                            rst_n = 1'b0;
  logic                            hsel = 1'b0;
  logic [31:0]                     haddr = 32'h0;
  logic [1:0]                      htrans = 2'h0;
  logic                            hwrite = 1'b0;
  logic [2:0]                      hsize = 3'h2;
  logic [31:0]                     hwdata = 32'h0;
  logic                            slow = 1'b0;
  logic                            hready, hreadyout, hresp, ee_req, ee_ack, load_done;
  logic [31:0]                     hrdata, rd;
  logic [7:0]                      ee_addr;
  logic [15:0]                     ee_data;
  epcl_port_cfg_t [EPCL_NPORT-1:0] port_cfg;
  logic [31:0]                     exp_q [6][5];
  logic [7:0]                      ofs [5] = '{8'h70, 8'h74, 8'h80, 8'h88, 8'hd4};
  int                              num_errors = 0;
  int                              total_checks = 0;
  int                              seed = 24765;
  // clock and single-slave ready
  always #2.5 sys_clk = ~sys_clk;
  assign hready = hreadyout;
  epcl_loader dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data), .load_done(load_done),
    .port_cfg(port_cfg));
  epcl_ee_model u_ee (.sys_clk(sys_clk), .rst_n(rst_n), .ee_req(ee_req), .ee_addr(ee_addr),
    .slow(slow), .ee_ack(ee_ack), .ee_data(ee_data));
  // ****
  // tasks
  // ****
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  // one single ahb-lite transfer; read data lands in rd
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20000);
    if (n >= 20000)
    begin
      num_errors++;
      results;
    end
    rd = hrdata;
  endtask
  // random eeprom image, then the expected fields from it
  task build;
    logic [15:0] w;
    for (int a = 0; a < 256; a++)
      u_ee.mem[a] = 16'($random(seed));
    for (int p = 0; p < 6; p++)
    begin
      w = u_ee.mem[8'h80 + 2 * p];
      exp_q[p][0] = {w[7], 31'h0};
      exp_q[p][1] = {17'h0, w[6:0], 8'h00};
      exp_q[p][2] = {u_ee.mem[8'hc0 + 2 * p], u_ee.mem[8'hb0 + 2 * p]};
      exp_q[p][3] = {w[15:8], 24'h0};
      exp_q[p][4] = (p == 0) ? 32'h0 : {u_ee.mem[8'ha0 + 2 * p], u_ee.mem[8'h90 + 2 * p]};
    end
  endtask
  // read every field over the bus and at the core side
  task sweep;
    for (int p = 0; p < 6; p++)
      for (int r = 0; r < 5; r++)
      begin
        ahb(1'b0, 32'(p * 256 + ofs[r]), 32'h0);
        chk("bus word", exp_q[p][r], rd);
        chk("core word", exp_q[p][r], port_cfg[p][159 - 32 * r -: 32]);
      end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    build;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    ahb(1'b0, 32'h074, 32'h0);
    chk("stalled read", exp_q[0][1], rd);
    chk("load done", 32'h1, {31'h0, load_done});
    sweep;
    ahb(1'b0, 32'(EPCL_ADR_STAT), 32'h0);
    chk("status word", {19'h0, EPCL_LAST_STEP, 8'h01}, rd);
    ahb(1'b1, 32'h4d4, 32'($random(seed)));
    ahb(1'b0, 32'h4d4, 32'h0);
    chk("read-only word", exp_q[4][4], rd);
    ahb(1'b0, 32'h0fc, 32'h0);
    chk("unmapped word", 32'h0, rd);
    slow <= 1'b1;
    build;
    ahb(1'b1, 32'h800, 32'h1);
    @(posedge sys_clk);
    chk("reload done", 32'h0, {31'h0, load_done});
    chk("reload slot", 32'h0, port_cfg[5].slot);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("reset request", 32'h0, {31'h0, ee_req});
    chk("reset vga", 32'h0, port_cfg[2].vga);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    sweep;
    results;
  end
  // watchdog
  initial
  begin
    #300000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
